//--- design/pffp_fifo.sv
// synchronous fifo with valid/ready on both sides
`timescale 1ns/100ps
module pffp_fifo #(
	parameter int W = pffp_pkg::REQ_W,
	parameter int DEPTH = pffp_pkg::FIFO_DEPTH
) (
	input wire logic i_clk,
	input wire logic i_rst,
	pffp_fifo_if.store q
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem [DEPTH];
	logic [AW:0] wr_ptr;
	logic [AW:0] rd_ptr;
	logic full;
	logic empty;

	// extra pointer bit tells full from empty
	assign empty = (wr_ptr == rd_ptr);
	assign full = (wr_ptr[AW] != rd_ptr[AW]) &&
		(wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
	assign q.push_ready = !full;
	assign q.pop_valid = !empty;
	assign q.pop_data = mem[rd_ptr[AW-1:0]];

	always_ff @(posedge i_clk) begin
		if (q.push_valid && !full) begin
			mem[wr_ptr[AW-1:0]] <= q.push_data;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			wr_ptr <= '0;
		end else if (q.push_valid && !full) begin
			wr_ptr <= wr_ptr + 1'b1;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			rd_ptr <= '0;
		end else if (q.pop_ready && !empty) begin
			rd_ptr <= rd_ptr + 1'b1;
		end
	end
endmodule : pffp_fifo

//--- design/pffp_fifo_if.sv
// request queue carrier between the port and its fifo
`timescale 1ns/100ps
interface pffp_fifo_if #(parameter int W = pffp_pkg::REQ_W) ();
	logic push_valid;
	logic push_ready;
	logic [W-1:0] push_data;
	logic pop_valid;
	logic pop_ready;
	logic [W-1:0] pop_data;
	modport fill (output push_valid, output push_data, input push_ready,
		input pop_valid, input pop_data, output pop_ready);
	modport store (input push_valid, input push_data, output push_ready,
		output pop_valid, output pop_data, input pop_ready);
endinterface : pffp_fifo_if

//--- design/pffp_pkg.sv
// constants shared by the parallel flash programming port
package pffp_pkg;
	localparam int BYTE_W = 8;
	localparam int ADDR_W = 32;
	localparam int OP_W = 4;
	localparam int TYPE_W = 4;
	localparam int PAGE_OFS_W = 7;
	localparam int FIFO_DEPTH = 8;
	localparam int REQ_W = OP_W + ADDR_W + BYTE_W;
	// transfer type selector codes
	localparam logic [TYPE_W-1:0] TYPE_CMD = 4'h0;
	localparam logic [TYPE_W-1:0] TYPE_ADDRESS_BYTE_0 = 4'h1;
	localparam logic [TYPE_W-1:0] TYPE_ADDRESS_BYTE_3 = 4'h4;
	localparam logic [TYPE_W-1:0] TYPE_DATA = 4'h5;
	// command byte codes
	localparam logic [BYTE_W-1:0] CMD_READ = 8'h11;
	localparam logic [BYTE_W-1:0] CMD_WP = 8'h12;
	localparam logic [BYTE_W-1:0] CMD_WPL = 8'h22;
	localparam logic [BYTE_W-1:0] CMD_EWP = 8'h32;
	localparam logic [BYTE_W-1:0] CMD_ERASE_WRITE_LOCK_CMD = 8'h42;
	localparam logic [BYTE_W-1:0] CMD_EA = 8'h13;
	localparam logic [BYTE_W-1:0] CMD_LOCK_SET = 8'h14;
	localparam logic [BYTE_W-1:0] CMD_LOCK_CLR = 8'h24;
	localparam logic [BYTE_W-1:0] CMD_LOCK_GET = 8'h15;
	localparam logic [BYTE_W-1:0] CMD_NVM_SET = 8'h34;
	localparam logic [BYTE_W-1:0] CMD_NVM_CLR = 8'h44;
	localparam logic [BYTE_W-1:0] CMD_NVM_GET = 8'h25;
	localparam logic [BYTE_W-1:0] CMD_SEC_SET = 8'h54;
	localparam logic [BYTE_W-1:0] CMD_SEC_GET = 8'h35;
	localparam logic [BYTE_W-1:0] CMD_VER_GET = 8'h1E;
	localparam logic [BYTE_W-1:0] CMD_NONE = 8'h00;
	// operations handed to the flash engine
	localparam logic [OP_W-1:0] OP_NONE = 4'h0;
	localparam logic [OP_W-1:0] OP_READ = 4'h1;
	localparam logic [OP_W-1:0] OP_WRITE = 4'h2;
	localparam logic [OP_W-1:0] OP_COMMIT = 4'h3;
	localparam logic [OP_W-1:0] OP_ERASE_ALL = 4'h4;
	localparam logic [OP_W-1:0] OP_LOCK_SET = 4'h5;
	localparam logic [OP_W-1:0] OP_LOCK_CLR = 4'h6;
	localparam logic [OP_W-1:0] OP_LOCK_GET = 4'h7;
	localparam logic [OP_W-1:0] OP_NVM_SET = 4'h8;
	localparam logic [OP_W-1:0] OP_NVM_CLR = 4'h9;
	localparam logic [OP_W-1:0] OP_NVM_GET = 4'hA;
	localparam logic [OP_W-1:0] OP_SEC_SET = 4'hB;
	localparam logic [OP_W-1:0] OP_SEC_GET = 4'hC;
	localparam logic [OP_W-1:0] OP_VER_GET = 4'hD;
	// flag bits in the data byte of a page commit
	localparam int COMMIT_ERASE_BIT = 0;
	localparam int COMMIT_LOCK_BIT = 1;
	localparam logic [ADDR_W-1:0] ADDR_RESET = 32'h0000_0000;
	localparam logic [BYTE_W-1:0] BYTE_RESET = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_STEP = 32'h0000_0001;
endpackage : pffp_pkg

//--- design/pffp_port.sv
// parallel flash programming port: handshake, decode, page buffer control
`timescale 1ns/100ps
module pffp_port #(
	parameter int PAGE_OFS_W = pffp_pkg::PAGE_OFS_W,
	parameter int FIFO_DEPTH = pffp_pkg::FIFO_DEPTH
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_test_strap,
	input wire logic i_prog_strap_0,
	input wire logic i_prog_strap_1,
	input wire logic i_prog_strap_2,
	input wire logic i_main_clock_in_fast,
	output logic o_use_main_clock_in,
	input wire logic i_command_strobe_n,
	input wire logic i_output_enable_n,
	input wire logic [pffp_pkg::TYPE_W-1:0] i_transfer_type_sel,
	input wire logic [pffp_pkg::BYTE_W-1:0] i_prog_data_bus,
	output logic [pffp_pkg::BYTE_W-1:0] o_prog_data_bus,
	output logic o_prog_data_bus_oe,
	output logic o_port_ready_out,
	output logic o_port_ready_oe,
	output logic o_data_valid_n,
	output logic o_data_valid_oe,
	output logic o_op_valid,
	input wire logic i_op_ready,
	output logic [pffp_pkg::OP_W-1:0] o_op_code,
	output logic [pffp_pkg::ADDR_W-1:0] o_op_addr,
	output logic [pffp_pkg::BYTE_W-1:0] o_op_data,
	input wire logic i_rsp_valid,
	input wire logic [pffp_pkg::BYTE_W-1:0] i_rsp_data
);
	typedef enum logic [3:0] {
		ST_OFF, ST_IDLE, ST_FLUSH, ST_ISSUE, ST_RSP, ST_OE_LO,
		ST_DRIVE, ST_REL, ST_STB_HI
	} pffp_state_e;

	pffp_state_e state;
	pffp_state_e next_state;
	logic strap_taken;
	logic clk_chosen;
	logic in_mode;
	logic [pffp_pkg::TYPE_W-1:0] lat_type;
	logic [pffp_pkg::BYTE_W-1:0] lat_byte;
	logic [pffp_pkg::BYTE_W-1:0] cmd;
	logic [pffp_pkg::ADDR_W-1:0] addr;
	logic [pffp_pkg::BYTE_W-1:0] rd_byte;
	logic dirty;
	logic need_commit;
	logic [pffp_pkg::ADDR_W-PAGE_OFS_W-1:0] buf_page;
	logic [pffp_pkg::BYTE_W-1:0] buf_cmd;
	logic is_write_cmd;
	logic is_read_cmd;
	logic [pffp_pkg::OP_W-1:0] data_op;
	logic strobe_take;
	logic commit_push;
	logic op_push;
	logic [pffp_pkg::BYTE_W-1:0] commit_flags;
	logic [pffp_pkg::OP_W-1:0] push_op;
	logic [pffp_pkg::ADDR_W-1:0] push_addr;
	logic [pffp_pkg::BYTE_W-1:0] push_byte;

	pffp_fifo_if #(.W(pffp_pkg::REQ_W)) req_q ();

	pffp_fifo #(.W(pffp_pkg::REQ_W), .DEPTH(FIFO_DEPTH)) u_req_fifo (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.q(req_q.store)
	);

	// command decode to engine operation
	always_comb begin
		unique case (cmd)
			pffp_pkg::CMD_READ: data_op = pffp_pkg::OP_READ;
			pffp_pkg::CMD_WP, pffp_pkg::CMD_WPL,
			pffp_pkg::CMD_EWP, pffp_pkg::CMD_ERASE_WRITE_LOCK_CMD:
				data_op = pffp_pkg::OP_WRITE;
			pffp_pkg::CMD_EA: data_op = pffp_pkg::OP_ERASE_ALL;
			pffp_pkg::CMD_LOCK_SET: data_op = pffp_pkg::OP_LOCK_SET;
			pffp_pkg::CMD_LOCK_CLR: data_op = pffp_pkg::OP_LOCK_CLR;
			pffp_pkg::CMD_LOCK_GET: data_op = pffp_pkg::OP_LOCK_GET;
			pffp_pkg::CMD_NVM_SET: data_op = pffp_pkg::OP_NVM_SET;
			pffp_pkg::CMD_NVM_CLR: data_op = pffp_pkg::OP_NVM_CLR;
			pffp_pkg::CMD_NVM_GET: data_op = pffp_pkg::OP_NVM_GET;
			pffp_pkg::CMD_SEC_SET: data_op = pffp_pkg::OP_SEC_SET;
			pffp_pkg::CMD_SEC_GET: data_op = pffp_pkg::OP_SEC_GET;
			pffp_pkg::CMD_VER_GET: data_op = pffp_pkg::OP_VER_GET;
			default: data_op = pffp_pkg::OP_NONE;
		endcase
	end

	assign is_write_cmd = (data_op == pffp_pkg::OP_WRITE);
	// queries answer through a read handshake
	assign is_read_cmd = (data_op == pffp_pkg::OP_READ) ||
		(data_op == pffp_pkg::OP_LOCK_GET) ||
		(data_op == pffp_pkg::OP_NVM_GET) ||
		(data_op == pffp_pkg::OP_SEC_GET) ||
		(data_op == pffp_pkg::OP_VER_GET);

	assign commit_flags = {{(pffp_pkg::BYTE_W-2){1'b0}},
		(buf_cmd == pffp_pkg::CMD_WPL) || (buf_cmd == pffp_pkg::CMD_ERASE_WRITE_LOCK_CMD),
		(buf_cmd == pffp_pkg::CMD_EWP) || (buf_cmd == pffp_pkg::CMD_ERASE_WRITE_LOCK_CMD)};

	// strap sampled once after reset release, never under reset
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			strap_taken <= 1'b0;
			in_mode <= 1'b0;
		end else if (!strap_taken) begin
			strap_taken <= 1'b1;
			in_mode <= i_test_strap && i_prog_strap_0 &&
				i_prog_strap_1 && !i_prog_strap_2;
		end
	end

	assign strobe_take = (state == ST_IDLE) && !i_command_strobe_n;

	// latch type and byte on the falling strobe
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			lat_type <= pffp_pkg::TYPE_CMD;
			lat_byte <= pffp_pkg::BYTE_RESET;
		end else if (strobe_take) begin
			lat_type <= i_transfer_type_sel;
			lat_byte <= i_prog_data_bus;
		end
	end

	// only the first strobe decides; later ones ignore the clock pin
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_use_main_clock_in <= 1'b0;
			clk_chosen <= 1'b0;
		end else if (strobe_take && !clk_chosen) begin
			o_use_main_clock_in <= i_main_clock_in_fast;
			clk_chosen <= 1'b1;
		end
	end

	// page commit decided at latch time
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			need_commit <= 1'b0;
		end else if (strobe_take) begin
			if (i_transfer_type_sel == pffp_pkg::TYPE_CMD) begin
				need_commit <= dirty;
			end else if (i_transfer_type_sel == pffp_pkg::TYPE_DATA) begin
				need_commit <= dirty && (!is_write_cmd ||
					addr[pffp_pkg::ADDR_W-1:PAGE_OFS_W] != buf_page);
			end else begin
				need_commit <= 1'b0;
			end
		end else if (commit_push && req_q.push_ready) begin
			need_commit <= 1'b0;
		end
	end

	assign commit_push = (state == ST_FLUSH) && need_commit;
	assign op_push = (state == ST_ISSUE) &&
		(lat_type == pffp_pkg::TYPE_DATA) &&
		(data_op != pffp_pkg::OP_NONE);

	always_comb begin
		if (commit_push) begin
			push_op = pffp_pkg::OP_COMMIT;
			push_addr = {buf_page, {PAGE_OFS_W{1'b0}}};
			push_byte = commit_flags;
		end else begin
			push_op = data_op;
			push_addr = addr;
			push_byte = lat_byte;
		end
	end

	assign req_q.push_valid = commit_push || op_push;
	assign req_q.push_data = {push_op, push_addr, push_byte};
	assign o_op_valid = req_q.pop_valid;
	assign req_q.pop_ready = i_op_ready;
	assign o_op_code = req_q.pop_data[pffp_pkg::REQ_W-1 -:
		pffp_pkg::OP_W];
	assign o_op_addr = req_q.pop_data[pffp_pkg::BYTE_W +:
		pffp_pkg::ADDR_W];
	assign o_op_data = req_q.pop_data[pffp_pkg::BYTE_W-1:0];

	// page load buffer bookkeeping
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			dirty <= 1'b0;
			buf_page <= '0;
			buf_cmd <= pffp_pkg::CMD_NONE;
		end else if (commit_push && req_q.push_ready) begin
			dirty <= 1'b0;
		end else if (op_push && req_q.push_ready && is_write_cmd) begin
			dirty <= 1'b1;
			buf_page <= addr[pffp_pkg::ADDR_W-1:PAGE_OFS_W];
			buf_cmd <= cmd;
		end
	end

	// command register; flush happens before the new one applies
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			cmd <= pffp_pkg::CMD_NONE;
		end else if (state == ST_ISSUE &&
				lat_type == pffp_pkg::TYPE_CMD) begin
			cmd <= lat_byte;
		end
	end

	// address bytes, then auto increment per data byte of a read or write command
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			addr <= pffp_pkg::ADDR_RESET;
		end else if (state == ST_ISSUE) begin
			if (lat_type >= pffp_pkg::TYPE_ADDRESS_BYTE_0 &&
					lat_type <= pffp_pkg::TYPE_ADDRESS_BYTE_3) begin
				addr[(lat_type - pffp_pkg::TYPE_ADDRESS_BYTE_0) *
					pffp_pkg::BYTE_W +: pffp_pkg::BYTE_W] <= lat_byte;
			end else if (op_push && req_q.push_ready &&
					(is_write_cmd || data_op == pffp_pkg::OP_READ)) begin
				addr <= addr + pffp_pkg::ADDR_STEP;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			rd_byte <= pffp_pkg::BYTE_RESET;
		end else if (state == ST_RSP && i_rsp_valid) begin
			rd_byte <= i_rsp_data;
		end
	end

	// handshake sequencer: pin levels, queue space and engine responses advance it
	always_comb begin
		next_state = state;
		unique case (state)
			ST_OFF: if (in_mode) next_state = ST_IDLE;
			ST_IDLE: if (strobe_take) next_state = ST_FLUSH;
			ST_FLUSH: if (!need_commit || req_q.push_ready) begin
				next_state = ST_ISSUE;
			end
			ST_ISSUE: begin
				if (op_push && !req_q.push_ready) begin
					next_state = ST_ISSUE;
				end else if (op_push && is_read_cmd) begin
					next_state = ST_RSP;
				end else begin
					next_state = ST_STB_HI;
				end
			end
			ST_RSP: if (i_rsp_valid) next_state = ST_OE_LO;
			ST_OE_LO: if (!i_output_enable_n) next_state = ST_DRIVE;
			ST_DRIVE: if (i_output_enable_n) next_state = ST_REL;
			ST_REL: next_state = ST_STB_HI;
			ST_STB_HI: if (i_command_strobe_n) next_state = ST_IDLE;
			default: next_state = ST_OFF;
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			state <= ST_OFF;
		end else begin
			state <= next_state;
		end
	end

	// pins stay inputs until the strap selects the mode
	assign o_port_ready_oe = in_mode;
	assign o_data_valid_oe = in_mode;
	assign o_port_ready_out = (state == ST_IDLE);
	assign o_data_valid_n = (state != ST_DRIVE);
	assign o_prog_data_bus_oe = (state == ST_DRIVE);
	assign o_prog_data_bus = rd_byte;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	sequence s_strobe_taken;
		state == ST_IDLE ##0 !i_command_strobe_n;
	endsequence
	sequence s_busy_after;
		!o_port_ready_out;
	endsequence

	a_ready_drops: assert property (
		s_strobe_taken |=> s_busy_after)
		else $error("ready did not drop after strobe");
	a_pins_off_mode: assert property (
		!in_mode |-> !o_port_ready_oe && !o_data_valid_oe &&
			!o_prog_data_bus_oe)
		else $error("pin driven outside programming mode");
	a_valid_bus_dir: assert property (
		(o_prog_data_bus_oe == !o_data_valid_n) &&
		(o_data_valid_n || $past(!i_output_enable_n)))
		else $error("data valid does not match bus direction");
	a_type_latched: assert property (
		s_strobe_taken |=> lat_type == $past(i_transfer_type_sel) &&
			lat_byte == $past(i_prog_data_bus))
		else $error("type and byte not latched at strobe");
	a_cmd_stored: assert property (
		state == ST_ISSUE && lat_type == pffp_pkg::TYPE_CMD |=>
			cmd == $past(lat_byte))
		else $error("command byte not stored");
	a_addr_incr: assert property (
		op_push && req_q.push_ready && is_write_cmd |=>
			addr == $past(addr) + pffp_pkg::ADDR_STEP)
		else $error("address did not advance");
	a_drive_wait_oe: assert property (
		$rose(o_prog_data_bus_oe) |-> $past(!i_output_enable_n))
		else $error("bus driven before output enable");
	a_release_oe: assert property (
		state == ST_DRIVE && i_output_enable_n |=> !o_prog_data_bus_oe)
		else $error("bus not released after output enable");
	a_ready_strobe: assert property (
		$rose(o_port_ready_out) && $past(state) == ST_STB_HI |->
			$past(i_command_strobe_n))
		else $error("ready rose while strobe low");
	a_commit_first: assert property (
		state == ST_FLUSH && need_commit && req_q.push_ready |->
			push_op == pffp_pkg::OP_COMMIT)
		else $error("page not committed first");
	a_commit_cmd: assert property (
		s_strobe_taken ##0 i_transfer_type_sel == pffp_pkg::TYPE_CMD
		##0 dirty |=> need_commit)
		else $error("new command did not flush page");
	a_clk_switch: assert property (
		!o_use_main_clock_in && !o_port_ready_out && state != ST_OFF &&
		$past(strobe_take) && $past(i_main_clock_in_fast) &&
		!$past(clk_chosen) |->
			o_use_main_clock_in)
		else $error("external clock not selected");
endmodule : pffp_port

//--- tb/pffp_port_tb.sv
// self-checking bench for the parallel flash programming port
`timescale 1ns/100ps
module pffp_port_tb;
	typedef struct {
		logic [3:0] t;
		logic [7:0] d;
		bit rd;
		logic [1:0] n;
		logic [3:0] op;
		logic [31:0] a;
		logic [7:0] x;
		logic [1:0] ck;
	} pffp_row_s;
	localparam int NROW = 41;
	// type, byte, read, new ops, first op code/addr/data, compare mask
	pffp_row_s rows [NROW] = '{
		'{4'h0,8'h22,1'h0,2'h0,4'h0,32'h0,8'h0,2'h0},
		'{4'h1,8'h7F,1'h0,2'h0,4'h0,32'h0,8'h0,2'h0},
		'{4'h2,8'h01,1'h0,2'h0,4'h0,32'h0,8'h0,2'h0},
		'{4'h3,8'h00,1'h0,2'h0,4'h0,32'h0,8'h0,2'h0},
		'{4'h4,8'h00,1'h0,2'h0,4'h0,32'h0,8'h0,2'h0},
		'{4'h5,8'h11,1'h0,2'h1,4'h2,32'h17F,8'h11,2'h3},
		'{4'h5,8'h22,1'h0,2'h2,4'h3,32'h100,8'h02,2'h3},
		'{4'h0,8'h32,1'h0,2'h1,4'h3,32'h180,8'h02,2'h3},
		'{4'h5,8'h33,1'h0,2'h1,4'h2,32'h181,8'h33,2'h3},
		'{4'h0,8'h42,1'h0,2'h1,4'h3,32'h180,8'h01,2'h3},
		'{4'h5,8'h44,1'h0,2'h1,4'h2,32'h182,8'h44,2'h3},
		'{4'h0,8'h11,1'h0,2'h1,4'h3,32'h180,8'h03,2'h3},
		'{4'h1,8'h00,1'h0,2'h0,4'h0,32'h0,8'h0,2'h0},
		'{4'h2,8'h02,1'h0,2'h0,4'h0,32'h0,8'h0,2'h0},
		'{4'h3,8'h00,1'h0,2'h0,4'h0,32'h0,8'h0,2'h0},
		'{4'h4,8'h00,1'h0,2'h0,4'h0,32'h0,8'h0,2'h0},
		'{4'h5,8'h00,1'h1,2'h1,4'h1,32'h200,8'h0,2'h1},
		'{4'h5,8'h00,1'h1,2'h1,4'h1,32'h201,8'h0,2'h1},
		'{4'h6,8'h55,1'h0,2'h0,4'h0,32'h0,8'h0,2'h0},
		'{4'h0,8'h77,1'h0,2'h0,4'h0,32'h0,8'h0,2'h0},
		'{4'h5,8'h66,1'h0,2'h0,4'h0,32'h0,8'h0,2'h0},
		'{4'h0,8'h13,1'h0,2'h0,4'h0,32'h0,8'h0,2'h0},
		'{4'h5,8'hA5,1'h0,2'h1,4'h4,32'h0,8'h0,2'h0},
		'{4'h0,8'h14,1'h0,2'h0,4'h0,32'h0,8'h0,2'h0},
		'{4'h5,8'h03,1'h0,2'h1,4'h5,32'h0,8'h03,2'h2},
		'{4'h0,8'h24,1'h0,2'h0,4'h0,32'h0,8'h0,2'h0},
		'{4'h5,8'h03,1'h0,2'h1,4'h6,32'h0,8'h03,2'h2},
		'{4'h0,8'h15,1'h0,2'h0,4'h0,32'h0,8'h0,2'h0},
		'{4'h5,8'h00,1'h1,2'h1,4'h7,32'h0,8'h0,2'h0},
		'{4'h0,8'h34,1'h0,2'h0,4'h0,32'h0,8'h0,2'h0},
		'{4'h5,8'h01,1'h0,2'h1,4'h8,32'h0,8'h01,2'h2},
		'{4'h0,8'h44,1'h0,2'h0,4'h0,32'h0,8'h0,2'h0},
		'{4'h5,8'h01,1'h0,2'h1,4'h9,32'h0,8'h01,2'h2},
		'{4'h0,8'h25,1'h0,2'h0,4'h0,32'h0,8'h0,2'h0},
		'{4'h5,8'h00,1'h1,2'h1,4'hA,32'h0,8'h0,2'h0},
		'{4'h0,8'h54,1'h0,2'h0,4'h0,32'h0,8'h0,2'h0},
		'{4'h5,8'h00,1'h0,2'h1,4'hB,32'h0,8'h00,2'h2},
		'{4'h0,8'h35,1'h0,2'h0,4'h0,32'h0,8'h0,2'h0},
		'{4'h5,8'h00,1'h1,2'h1,4'hC,32'h0,8'h0,2'h0},
		'{4'h0,8'h1E,1'h0,2'h0,4'h0,32'h0,8'h0,2'h0},
		'{4'h5,8'h00,1'h1,2'h1,4'hD,32'h0,8'h0,2'h0}
	};
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic tst = 1'b1;
	logic s0 = 1'b1;
	logic s1 = 1'b1;
	logic s2 = 1'b0;
	logic fast = 1'b0;
	logic op_ready = 1'b1;
	logic rsp_valid = 1'b0;
	logic [7:0] rsp_data = 8'h00;
	logic use_clk, bus_oe, rdy, rdy_oe, vld_n, vld_oe, op_valid;
	logic [7:0] bus_out, op_data, pdata, q, rsp_next;
	logic [3:0] op_code, ptype, cap_c;
	logic [31:0] op_addr, cap_a;
	logic strobe_n, oe_n, pdrive, cap;
	logic [43:0] opq [$];
	logic [43:0] o;
	int fails = 0;
	int checks_done = 0;
	int cyc = 0;
	int rsp_cnt = 0;
	int base, t0;
	wire logic [7:0] bus_pin = bus_oe ? bus_out : (pdrive ? pdata : 8'hFF);
	wire logic rdy_pin = rdy_oe ? rdy : 1'b1;
	wire logic vld_pin = vld_oe ? vld_n : 1'b1;

	pffp_port i_pffp_port (.i_clk(clk), .i_rst(rst), .i_test_strap(tst),
		.i_prog_strap_0(s0), .i_prog_strap_1(s1), .i_prog_strap_2(s2),
		.i_main_clock_in_fast(fast), .o_use_main_clock_in(use_clk),
		.i_command_strobe_n(strobe_n), .i_output_enable_n(oe_n),
		.i_transfer_type_sel(ptype), .i_prog_data_bus(bus_pin),
		.o_prog_data_bus(bus_out), .o_prog_data_bus_oe(bus_oe),
		.o_port_ready_out(rdy), .o_port_ready_oe(rdy_oe),
		.o_data_valid_n(vld_n), .o_data_valid_oe(vld_oe),
		.o_op_valid(op_valid), .i_op_ready(op_ready), .o_op_code(op_code),
		.o_op_addr(op_addr), .o_op_data(op_data), .i_rsp_valid(rsp_valid),
		.i_rsp_data(rsp_data));
	pffp_prog_model i_pffp_prog_model (.i_clk(clk), .i_ready(rdy_pin),
		.i_valid_n(vld_pin), .i_data(bus_pin), .o_strobe_n(strobe_n),
		.o_oe_n(oe_n), .o_type(ptype), .o_data(pdata), .o_drive(pdrive));

	initial begin
		forever #2 clk = ~clk;
	end

	// flash engine stand-in: logs ops, answers queries after three cycles
	always @(posedge clk) begin
		cap = (op_valid === 1'b1) && op_ready;
		cap_c = op_code;
		cap_a = op_addr;
		if (cap) opq.push_back({op_code, op_addr, op_data});
		#1;
		rsp_valid = 1'b0;
		if (cap && cap_c inside {4'h1, 4'h7, 4'hA, 4'hC, 4'hD}) begin
			rsp_cnt = 3;
			rsp_next = (cap_c == 4'h1) ? cap_a[7:0] ^ 8'h5A : {4'hC, cap_c};
		end else if (rsp_cnt > 0) begin
			rsp_cnt--;
			rsp_valid = (rsp_cnt == 0);
			rsp_data = rsp_next;
		end
	end

	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			end_sim();
		end
	end

	task automatic chk(input logic [43:0] seen, input logic [43:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
		end
	endtask : chk

	task automatic end_sim();
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : end_sim

	task automatic do_reset(input logic s2v, input logic fv);
		@(posedge clk);
		#1;
		rst = 1'b1;
		s2 = s2v;
		fast = fv;
		repeat (16) @(posedge clk);
		chk({rdy_oe, vld_oe, bus_oe, rdy_pin, vld_pin, bus_pin}, 13'h03FF);
		#1;
		rst = 1'b0;
		repeat (4) @(posedge clk);
	endtask : do_reset

	initial begin
		do_reset(1'b0, 1'b0);
		chk({rdy_oe, rdy, vld_n, bus_oe}, 4'hE);
		for (int i = 0; i < NROW; i++) begin
			base = opq.size();
			i_pffp_prog_model.xfer(rows[i].t, rows[i].d, rows[i].rd, q);
			repeat (6) @(posedge clk);
			chk(44'(opq.size() - base), 44'(rows[i].n));
			if (rows[i].n > 0) begin
				o = opq[base];
				chk(o[43:40], rows[i].op);
				if (rows[i].ck[0]) chk(o[39:8], rows[i].a);
				if (rows[i].ck[1]) chk(o[7:0], rows[i].x);
			end
			if (rows[i].rd) chk(q, (rows[i].op == 4'h1) ?
				rows[i].a[7:0] ^ 8'h5A : {4'hC, rows[i].op});
		end
		chk(use_clk, 1'b0);
		// stall the engine so the queue fills and handshakes must wait
		i_pffp_prog_model.xfer(4'h0, 8'h12, 1'b0, q);
		for (int k = 1; k < 5; k++) begin
			i_pffp_prog_model.xfer(4'(k), (k == 2) ? 8'h03 : 8'h00, 1'b0, q);
		end
		#1;
		op_ready = 1'b0;
		base = opq.size();
		t0 = cyc;
		fork
			begin
				repeat (150) @(posedge clk);
				#1;
				op_ready = 1'b1;
			end
		join_none
		for (int k = 0; k < 12; k++) begin
			i_pffp_prog_model.xfer(4'h5, 8'(k), 1'b0, q);
		end
		repeat (6) @(posedge clk);
		chk(44'(cyc - t0 >= 150), 44'h1);
		chk(44'(opq.size() - base), 44'hC);
		chk(opq[base + 11], {4'h2, 32'h30B, 8'h0B});
		// a fast clock that shows up after the first strobe is ignored
		#1;
		fast = 1'b1;
		i_pffp_prog_model.xfer(4'h6, 8'h00, 1'b0, q);
		chk(use_clk, 1'b0);
		do_reset(1'b1, 1'b0);
		chk(rdy_oe, 1'b0);
		do_reset(1'b0, 1'b1);
		chk(use_clk, 1'b0);
		i_pffp_prog_model.xfer(4'h0, 8'h11, 1'b0, q);
		chk(use_clk, 1'b1);
		end_sim();
	end
endmodule : pffp_port_tb

//--- tb/pffp_prog_model.sv
// gang programmer side of the parallel handshake
`timescale 1ns/100ps
module pffp_prog_model (
	input wire logic i_clk,
	input wire logic i_ready,
	input wire logic i_valid_n,
	input wire logic [7:0] i_data,
	output logic o_strobe_n,
	output logic o_oe_n,
	output logic [3:0] o_type,
	output logic [7:0] o_data,
	output logic o_drive
);
	initial begin
		o_strobe_n = 1'b1;
		o_oe_n = 1'b1;
		o_type = 4'hF;
		o_data = 8'hFF;
		o_drive = 1'b0;
	end

	// paced only by ready and valid, never by fixed delays
	task automatic xfer(input logic [3:0] t, input logic [7:0] d,
		input bit rd, output logic [7:0] q);
		q = 8'h00;
		@(posedge i_clk);
		#1;
		o_type = t;
		o_data = d;
		o_drive = 1'b1;
		o_strobe_n = 1'b0;
		do @(posedge i_clk); while (i_ready !== 1'b0);
		#1;
		// released lines fall back to their pull-ups
		o_drive = 1'b0;
		o_type = 4'hF;
		if (rd) begin
			o_oe_n = 1'b0;
			do @(posedge i_clk); while (i_valid_n !== 1'b0);
			q = i_data;
			#1;
			o_oe_n = 1'b1;
			do @(posedge i_clk); while (i_valid_n !== 1'b1);
			#1;
		end
		o_strobe_n = 1'b1;
		do @(posedge i_clk); while (i_ready !== 1'b1);
	endtask : xfer
endmodule : pffp_prog_model
